// ===== hw/aps_pkg.sv
// constants and types for the auxiliary port with chip-select strobes
// What this block does
// [R1] four aux pins, each pin configured on its own
// [R2] four modes per pin, set by fields in two pin-mode control registers
// [R3] mode 0: quasi-bidirectional port bit with pull-up, driven from port data bit
// [R4] mode 0: pin 2 feeds ext_irq_b, pin 3 feeds ext_irq_a, when enabled
// [R5] mode 1: read strobe follows bus read pulse on address match
// [R6] mode 2: write strobe follows bus write pulse on address match
// [R7] mode 3: strobe on read or write pulse with matching address
// [R8] per-pin 16-bit base comparator from high and low base registers
// [R9] low address lines can be masked; masking A1:A0 covers four addresses
// [R10] invert bit set to one makes that pin's strobe active high
// [R11] port data writes drive only mode-0 pins; strobe pins keep strobing
// [R12] port data uses bits 3 to 0; bits 7 to 4 reserved
// [R13] irq control register is bit-addressable; irq a enable at bit 0c2h
// [R14] with invert bit zero the strobe is active low
package aps_pkg;
   localparam int APS_PINS = 4;
   localparam logic [7:0] APS_ADDR_IRQ_CTRL = 8'hc0;
   localparam logic [7:0] APS_ADDR_PORT_DATA = 8'he8;
   localparam logic [7:0] APS_ADDR_MODE_A = 8'hd2;
   localparam logic [7:0] APS_ADDR_MODE_B = 8'hd3;
   localparam logic [7:0] APS_ADDR_EXT_CTRL = 8'hae;
   localparam logic [7:0] APS_ADDR_BASE_HI0 = 8'hd4;
   localparam logic [7:0] APS_ADDR_BASE_LO0 = 8'hdc;
   localparam logic [7:0] APS_BIT_MASK_HI = 8'hf8;
   localparam int APS_FIELD_W = 4;
   localparam int APS_MODE_LSB = 2;
   localparam int APS_MASK_LSB = 0;
   localparam int APS_INV_LSB = 4;
   localparam int APS_IRQ_A_EN_BIT = 2;
   localparam int APS_IRQ_B_EN_BIT = 6;
   localparam int APS_IRQ_A_PIN = 3;
   localparam int APS_IRQ_B_PIN = 2;
   localparam logic [3:0] APS_PORT_RST = 4'hf;
   localparam logic [7:0] APS_REG_RST = 8'h00;
   typedef enum logic [1:0] {APS_MODE_PORT, APS_MODE_RD, APS_MODE_WR, APS_MODE_RW} aps_mode_t;
endpackage

// ===== hw/aps_strobe_if.sv
// carrier between register side and strobe decoder
`timescale 1ns/100ps
interface aps_strobe_if;
   import aps_pkg::*;
   aps_mode_t mode [APS_PINS];
   logic [1:0] mask [APS_PINS];
   logic [15:0] base [APS_PINS];
   logic [15:0] addr;
   logic rd_act;
   logic wr_act;
   logic [APS_PINS-1:0] hit;
   modport cfg (output mode, output mask, output base, output addr, output rd_act,
      output wr_act, input hit);
   modport gen (input mode, input mask, input base, input addr, input rd_act,
      input wr_act, output hit);
endinterface

// ===== hw/aps_strobe_gen.sv
// per-pin address comparator and strobe select
`timescale 1ns/100ps
module aps_strobe_gen
   import aps_pkg::*;
(
   aps_strobe_if.gen sif
);
   // compare with 0..3 low address lines masked
   function automatic logic addr_match(logic [15:0] base, logic [15:0] addr,
      logic [1:0] mask);
      logic [15:0] care;
      care = 16'hffff << mask;
      return ((base ^ addr) & care) == 16'h0000; // see [R8] see [R9]
   endfunction

   genvar i;
   generate
      for (i = 0; i < APS_PINS; i++)
      begin : g_pin
         logic hit_addr;
         logic pulse;
         assign hit_addr = addr_match(sif.base[i], sif.addr, sif.mask[i]);
         always_comb
         begin
            unique case (sif.mode[i])
               APS_MODE_PORT: pulse = 1'b0;
               APS_MODE_RD: pulse = sif.rd_act; // see [R5]
               APS_MODE_WR: pulse = sif.wr_act; // see [R6]
               APS_MODE_RW: pulse = sif.rd_act | sif.wr_act; // see [R7]
            endcase
         end
         assign sif.hit[i] = pulse & hit_addr;
      end
   endgenerate
endmodule // aps_strobe_gen

// ===== hw/aps_aux_port.sv
// auxiliary port: special-function registers, pin drivers, irq taps
`timescale 1ns/100ps
module aps_aux_port
   import aps_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic sfr_bit_wr,
   input wire logic [7:0] sfr_bit_addr,
   input wire logic sfr_bit_val,
   output logic [7:0] sfr_rdata,
   input wire logic [15:0] ext_addr,
   input wire logic ext_rd_n,
   input wire logic ext_wr_n,
   input wire logic [3:0] pin_in,
   output logic [3:0] pin_out,
   output logic [3:0] pin_oe_n,
   output logic ext_irq_a_n,
   output logic ext_irq_b_n
);
   logic [3:0] port_data_ff, nxt_port_data;
   logic [7:0] irq_ctrl_ff, nxt_irq_ctrl;
   logic [7:0] mode_a_ff, nxt_mode_a;
   logic [7:0] mode_b_ff, nxt_mode_b;
   logic [7:0] ext_ctrl_ff, nxt_ext_ctrl;
   logic [7:0] base_hi_ff [APS_PINS];
   logic [7:0] nxt_base_hi [APS_PINS];
   logic [7:0] base_lo_ff [APS_PINS];
   logic [7:0] nxt_base_lo [APS_PINS];
   logic [7:0] rdata_ff, nxt_rdata;
   logic [3:0] out_ff, nxt_out;
   logic [3:0] oe_n_ff, nxt_oe_n;
   logic irq_a_ff, nxt_irq_a;
   logic irq_b_ff, nxt_irq_b;
   logic [15:0] mode_all;
   logic [3:0] inv;

   aps_strobe_if sif ();

   // per-pin configuration field
   function automatic logic [3:0] pin_field(logic [15:0] all, int pin);
      return all[pin*APS_FIELD_W +: APS_FIELD_W];
   endfunction

   function automatic aps_mode_t pin_mode(logic [15:0] all, int pin);
      logic [3:0] f;
      f = pin_field(all, pin);
      return aps_mode_t'(f[APS_MODE_LSB +: 2]);
   endfunction

   assign mode_all = {mode_b_ff, mode_a_ff}; // see [R2]
   assign inv = ext_ctrl_ff[APS_INV_LSB +: APS_PINS];

   genvar g;
   generate
      for (g = 0; g < APS_PINS; g++)
      begin : g_cfg
         logic [3:0] fld;
         assign fld = pin_field(mode_all, g);
         assign sif.mode[g] = pin_mode(mode_all, g); // see [R1]
         assign sif.mask[g] = fld[APS_MASK_LSB +: 2];
         assign sif.base[g] = {base_hi_ff[g], base_lo_ff[g]}; // see [R8]
      end
   endgenerate
   assign sif.addr = ext_addr;
   assign sif.rd_act = ~ext_rd_n;
   assign sif.wr_act = ~ext_wr_n;

   aps_strobe_gen u_gen (
      .sif(sif.gen)
   );

   // register writes, byte then bit
   always_comb
   begin
      nxt_port_data = port_data_ff;
      nxt_irq_ctrl = irq_ctrl_ff;
      nxt_mode_a = mode_a_ff;
      nxt_mode_b = mode_b_ff;
      nxt_ext_ctrl = ext_ctrl_ff;
      nxt_base_hi = base_hi_ff;
      nxt_base_lo = base_lo_ff;
      if (sfr_wr)
      begin
         unique case (sfr_addr)
            APS_ADDR_PORT_DATA: nxt_port_data = sfr_wdata[3:0]; // see [R12]
            APS_ADDR_IRQ_CTRL: nxt_irq_ctrl = sfr_wdata;
            APS_ADDR_MODE_A: nxt_mode_a = sfr_wdata;
            APS_ADDR_MODE_B: nxt_mode_b = sfr_wdata;
            APS_ADDR_EXT_CTRL: nxt_ext_ctrl = sfr_wdata;
            default:
            begin
               for (int i = 0; i < APS_PINS; i++)
               begin
                  if (sfr_addr == APS_ADDR_BASE_HI0 + 8'(i))
                     nxt_base_hi[i] = sfr_wdata;
                  if (sfr_addr == APS_ADDR_BASE_LO0 + 8'(i))
                     nxt_base_lo[i] = sfr_wdata;
               end
            end
         endcase
      end
      if (sfr_bit_wr)
      begin
         if ((sfr_bit_addr & APS_BIT_MASK_HI) == APS_ADDR_IRQ_CTRL)
            nxt_irq_ctrl[sfr_bit_addr[2:0]] = sfr_bit_val; // see [R13]
         if ((sfr_bit_addr & APS_BIT_MASK_HI) == APS_ADDR_PORT_DATA && !sfr_bit_addr[2])
            nxt_port_data[sfr_bit_addr[1:0]] = sfr_bit_val;
      end
   end

   // read data, unmapped reads zero
   always_comb
   begin
      nxt_rdata = 8'h00;
      if (sfr_rd)
      begin
         unique case (sfr_addr)
            APS_ADDR_PORT_DATA: nxt_rdata = {4'h0, pin_in}; // see [R12]
            APS_ADDR_IRQ_CTRL: nxt_rdata = irq_ctrl_ff;
            APS_ADDR_MODE_A: nxt_rdata = mode_a_ff;
            APS_ADDR_MODE_B: nxt_rdata = mode_b_ff;
            APS_ADDR_EXT_CTRL: nxt_rdata = ext_ctrl_ff;
            default:
            begin
               for (int i = 0; i < APS_PINS; i++)
               begin
                  if (sfr_addr == APS_ADDR_BASE_HI0 + 8'(i))
                     nxt_rdata = base_hi_ff[i];
                  if (sfr_addr == APS_ADDR_BASE_LO0 + 8'(i))
                     nxt_rdata = base_lo_ff[i];
               end
            end
         endcase
      end
   end

   // pin drivers and irq taps
   always_comb
   begin
      for (int i = 0; i < APS_PINS; i++)
      begin
         if (sif.mode[i] == APS_MODE_PORT)
         begin
            nxt_out[i] = 1'b0; // see [R3]
            nxt_oe_n[i] = port_data_ff[i]; // see [R3] see [R11]
         end
         else
         begin
            nxt_out[i] = sif.hit[i] ~^ inv[i]; // see [R10] see [R14]
            nxt_oe_n[i] = 1'b0; // see [R11]
         end
      end
      nxt_irq_a = 1'b1;
      nxt_irq_b = 1'b1;
      if (sif.mode[APS_IRQ_A_PIN] == APS_MODE_PORT && irq_ctrl_ff[APS_IRQ_A_EN_BIT])
         nxt_irq_a = pin_in[APS_IRQ_A_PIN]; // see [R4]
      if (sif.mode[APS_IRQ_B_PIN] == APS_MODE_PORT && irq_ctrl_ff[APS_IRQ_B_EN_BIT])
         nxt_irq_b = pin_in[APS_IRQ_B_PIN]; // see [R4]
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         port_data_ff <= APS_PORT_RST;
         irq_ctrl_ff <= APS_REG_RST;
         mode_a_ff <= APS_REG_RST;
         mode_b_ff <= APS_REG_RST;
         ext_ctrl_ff <= APS_REG_RST;
         for (int i = 0; i < APS_PINS; i++)
         begin
            base_hi_ff[i] <= APS_REG_RST;
            base_lo_ff[i] <= APS_REG_RST;
         end
         rdata_ff <= APS_REG_RST;
         out_ff <= 4'h0;
         oe_n_ff <= 4'hf;
         irq_a_ff <= 1'b1;
         irq_b_ff <= 1'b1;
      end
      else
      begin
         port_data_ff <= nxt_port_data;
         irq_ctrl_ff <= nxt_irq_ctrl;
         mode_a_ff <= nxt_mode_a;
         mode_b_ff <= nxt_mode_b;
         ext_ctrl_ff <= nxt_ext_ctrl;
         base_hi_ff <= nxt_base_hi;
         base_lo_ff <= nxt_base_lo;
         rdata_ff <= nxt_rdata;
         out_ff <= nxt_out;
         oe_n_ff <= nxt_oe_n;
         irq_a_ff <= nxt_irq_a;
         irq_b_ff <= nxt_irq_b;
      end
   end

   assign sfr_rdata = rdata_ff;
   assign pin_out = out_ff;
   assign pin_oe_n = oe_n_ff;
   assign ext_irq_a_n = irq_a_ff;
   assign ext_irq_b_n = irq_b_ff;

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_wr_pulse;
      !ext_wr_n;
   endsequence
   sequence s_rd_pulse;
      !ext_rd_n;
   endsequence
   sequence s_pin0_near_base;
      ext_addr[15:2] == {base_hi_ff[0], base_lo_ff[0][7:2]};
   endsequence
   sequence s_pin1_near_base;
      ext_addr[15:3] == {base_hi_ff[1], base_lo_ff[1][7:3]};
   endsequence

   a_port_drive_low: assert property ( // see [R3]
      sif.mode[1] == APS_MODE_PORT && !port_data_ff[1] |=> !pin_oe_n[1] && !pin_out[1])
      else $error("mode 0 pin 1 not driven low");
   a_port_release: assert property ( // see [R3]
      sif.mode[1] == APS_MODE_PORT && port_data_ff[1] |=> pin_oe_n[1])
      else $error("mode 0 pin 1 not released");
   a_irq_a_follow: assert property ( // see [R4]
      sif.mode[3] == APS_MODE_PORT && irq_ctrl_ff[2] |=> ext_irq_a_n == $past(pin_in[3]))
      else $error("irq a does not follow pin 3");
   a_irq_b_follow: assert property ( // see [R4]
      sif.mode[2] == APS_MODE_PORT && irq_ctrl_ff[6] |=> ext_irq_b_n == $past(pin_in[2]))
      else $error("irq b does not follow pin 2");
   a_irq_a_quiet: assert property ( // see [R4]
      !irq_ctrl_ff[2] || sif.mode[3] != APS_MODE_PORT |=> ext_irq_a_n)
      else $error("irq a active while disabled");
   a_rd_strobe_low: assert property ( // see [R5]
      sif.mode[0] == APS_MODE_RD && !inv[0] && sif.mask[0] == 2'd2
      ##0 s_rd_pulse ##0 s_pin0_near_base |=> !pin_out[0])
      else $error("read strobe missing on pin 0");
   a_wr_not_on_rd: assert property ( // see [R6]
      sif.mode[0] == APS_MODE_WR && ext_wr_n && !inv[0] |=> pin_out[0])
      else $error("write strobe without write pulse");
   a_rw_strobe_wr: assert property ( // see [R7]
      sif.mode[0] == APS_MODE_RW && !inv[0] && sif.mask[0] == 2'd2
      ##0 s_wr_pulse ##0 s_pin0_near_base |=> !pin_out[0] && !pin_oe_n[0])
      else $error("read/write strobe missing on pin 0");
   a_mask_four: assert property ( // see [R9]
      sif.mode[0] == APS_MODE_WR && inv[0] && sif.mask[0] == 2'd2
      ##0 s_wr_pulse ##0 s_pin0_near_base |=> pin_out[0])
      else $error("masked range not covered on pin 0");
   a_strobe_keeps: assert property ( // see [R11]
      sfr_wr && sfr_addr == APS_ADDR_PORT_DATA && sif.mode[2] != APS_MODE_PORT
      ##1 sif.mode[2] != APS_MODE_PORT |=> !pin_oe_n[2])
      else $error("port write disturbed strobe pin");
   a_reserved_zero: assert property ( // see [R12]
      sfr_rd && sfr_addr == APS_ADDR_PORT_DATA |=> sfr_rdata[7:4] == 4'h0)
      else $error("reserved port bits not zero");
   a_bit_enable_a: assert property ( // see [R13]
      sfr_bit_wr && sfr_bit_addr == 8'hc2 && !sfr_wr |=> irq_ctrl_ff[2] == $past(sfr_bit_val))
      else $error("bit write to 0c2h missed");
   a_port0_drive: assert property ( // see [R3] see [R11]
      sif.mode[0] == APS_MODE_PORT |=> pin_oe_n[0] == $past(port_data_ff[0]) && !pin_out[0])
      else $error("mode 0 pin 0 drive wrong");
   a_port3_drive: assert property ( // see [R3] see [R11]
      sif.mode[3] == APS_MODE_PORT |=> pin_oe_n[3] == $past(port_data_ff[3]) && !pin_out[3])
      else $error("mode 0 pin 3 drive wrong");
   a_irq_b_quiet: assert property ( // see [R4]
      !irq_ctrl_ff[6] || sif.mode[2] != APS_MODE_PORT |=> ext_irq_b_n)
      else $error("irq b active while disabled");
   a_rd_not_on_wr: assert property ( // see [R5]
      sif.mode[0] == APS_MODE_RD && ext_rd_n && !inv[0] |=> pin_out[0])
      else $error("read strobe without read pulse");
   a_wr_strobe_pin1: assert property ( // see [R6]
      sif.mode[1] == APS_MODE_WR && inv[1] && sif.mask[1] == 2'd3
      ##0 s_wr_pulse ##0 s_pin1_near_base |=> pin_out[1])
      else $error("write strobe missing on pin 1");
   a_rw_strobe_rd: assert property ( // see [R7]
      sif.mode[0] == APS_MODE_RW && !inv[0] && sif.mask[0] == 2'd2
      ##0 s_rd_pulse ##0 s_pin0_near_base |=> !pin_out[0])
      else $error("read/write strobe missing on read");
   a_rw_idle_high: assert property ( // see [R7] see [R14]
      sif.mode[0] == APS_MODE_RW && !inv[0] && ext_rd_n && ext_wr_n |=> pin_out[0])
      else $error("read/write strobe without pulse");
   a_high_byte_miss: assert property ( // see [R8]
      sif.mode[0] != APS_MODE_PORT && !inv[0] && ext_addr[15:8] != base_hi_ff[0] |=> pin_out[0])
      else $error("strobe on high byte mismatch");
   a_inv_idle_low: assert property ( // see [R10]
      sif.mode[0] != APS_MODE_PORT && inv[0] && ext_rd_n && ext_wr_n |=> !pin_out[0])
      else $error("inverted strobe not idle low");
   a_strobe_driven: assert property ( // see [R11]
      sif.mode[0] != APS_MODE_PORT |=> !pin_oe_n[0])
      else $error("strobe pin 0 not driven");
   a_mode_a_read: assert property ( // see [R2]
      sfr_rd && sfr_addr == APS_ADDR_MODE_A |=> sfr_rdata == $past(mode_a_ff))
      else $error("mode register a read wrong");
   a_base_lo_write: assert property ( // see [R8]
      sfr_wr && sfr_addr == APS_ADDR_BASE_LO0 |=> base_lo_ff[0] == $past(sfr_wdata))
      else $error("base low byte write missed");
   a_port_byte_write: assert property ( // see [R12]
      sfr_wr && sfr_addr == APS_ADDR_PORT_DATA && !sfr_bit_wr
      |=> port_data_ff == $past(sfr_wdata[3:0]))
      else $error("port data byte write wrong");
   a_pin3_mode_field: assert property ( // see [R1]
      sfr_wr && sfr_addr == APS_ADDR_MODE_B |=> sif.mode[3] == aps_mode_t'($past(sfr_wdata[7:6])))
      else $error("pin 3 mode field wrong");
endmodule // aps_aux_port

// ===== testbench/aps_pad_model.sv
// pad model: pull-ups plus a peripheral that can pull pins low
`timescale 1ns/100ps
module aps_pad_model
(
   input wire logic [3:0] pin_out,
   input wire logic [3:0] pin_oe_n,
   input wire logic [3:0] pull_low,
   output logic [3:0] pin_in
);
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         pin_in[i] = pin_oe_n[i] ? ~pull_low[i] : pin_out[i];
      end
   end
endmodule // aps_pad_model

// ===== testbench/aps_aux_port_bench.sv
// self-checking bench for the auxiliary port
`timescale 1ns/100ps
module aps_aux_port_bench;
   import aps_pkg::*;
   logic clk, rst, sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_val, ext_rd_n, ext_wr_n;
   logic ext_irq_a_n, ext_irq_b_n;
   logic [7:0] sfr_addr, sfr_wdata, sfr_bit_addr, sfr_rdata, e;
   logic [15:0] ext_addr;
   logic [3:0] pin_in, pin_out, pin_oe_n, pull_low;
   int error_cnt = 0;
   int n_tests = 0;
   int md [4];
   int mk [4];
   int iv [4];
   int bs [4];
   int sel, a, r;
   logic [3:0] exp_q [$];
   aps_aux_port aps_aux_port_inst(.clk(clk), .rst(rst), .sfr_addr(sfr_addr),
      .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_bit_wr(sfr_bit_wr),
      .sfr_bit_addr(sfr_bit_addr), .sfr_bit_val(sfr_bit_val), .sfr_rdata(sfr_rdata),
      .ext_addr(ext_addr), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_irq_a_n(ext_irq_a_n),
      .ext_irq_b_n(ext_irq_b_n));
   aps_pad_model aps_pad_model_inst(.pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .pull_low(pull_low), .pin_in(pin_in));
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic end_of_test;
      if (error_cnt == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk_reg(input logic [7:0] got, input logic [7:0] want);
      n_tests++;
      if (got !== want)
      begin
         error_cnt++;
         $display("MISMATCH %0t reg got %h want %h", $time, got, want);
      end
   endtask
   task automatic chk_pin(input logic [7:0] got, input logic [7:0] want);
      n_tests++;
      if (got !== want)
      begin
         error_cnt++;
         $display("MISMATCH %0t pins got %h want %h", $time, got, want);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      sfr_addr = ad;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      cyc(1);
      sfr_wr = 1'b0;
      cyc(1);
   endtask
   task automatic bw(input logic [7:0] ad, input logic v);
      sfr_bit_addr = ad;
      sfr_bit_val = v;
      sfr_bit_wr = 1'b1;
      cyc(1);
      sfr_bit_wr = 1'b0;
      cyc(1);
   endtask
   task automatic rd(input logic [7:0] ad, input logic [7:0] want);
      sfr_addr = ad;
      sfr_rd = 1'b1;
      cyc(1);
      sfr_rd = 1'b0;
      chk_reg(sfr_rdata, want);
      cyc(1);
   endtask
   function automatic logic strobe(int p, int ad, int rn, int wn);
      int hit;
      hit = int'(((ad & 'hffff) >> mk[p]) == (bs[p] >> mk[p]));
      hit = hit & int'((md[p] != 2 && rn == 0) || (md[p] != 1 && wn == 0));
      return 1'(hit == iv[p]);
   endfunction
   initial
   begin
      #100000;
      error_cnt++;
      end_of_test();
   end
   initial
   begin
      void'($urandom(69));
      {rst, sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_val} = 5'h11;
      {sfr_addr, sfr_wdata, sfr_bit_addr, ext_addr, pull_low} = 44'h0;
      {ext_rd_n, ext_wr_n} = 2'h3;
      cyc(6);
      rst = 1'b0;
      cyc(1);
      rd(APS_ADDR_PORT_DATA, 8'h0f);
      wr(8'h00, 8'hff);
      rd(8'h00, 8'h00);
      for (int k = 0; k < 4; k++)
      begin
         r = $urandom_range(255);
         wr(APS_ADDR_PORT_DATA, r[7:0]);
         cyc(1);
         chk_pin({pin_oe_n, pin_out}, {r[3:0], 4'h0});
         rd(APS_ADDR_PORT_DATA, {4'h0, r[3:0]});
      end
      wr(APS_ADDR_PORT_DATA, 8'h0f);
      bw(8'he9, 1'b0);
      cyc(1);
      chk_pin({pin_oe_n, pin_out}, 8'hd0);
      for (int k = 0; k < 6; k++)
      begin
         if (k == 2)
            bw(8'hc2, 1'b1);
         if (k == 4)
            wr(APS_ADDR_IRQ_CTRL, 8'h44);
         pull_low = 4'($urandom_range(15)) & 4'hc;
         cyc(2);
         e = {6'h0, k < 2 | ~pull_low[3], k < 4 | ~pull_low[2]};
         chk_pin({6'h0, ext_irq_a_n, ext_irq_b_n}, e);
      end
      rd(APS_ADDR_IRQ_CTRL, 8'h44);
      pull_low = 4'h0;
      // five passes so every pin meets each strobe mode and polarity
      for (int q = 0; q < 5; q++)
      begin
         for (int p = 0; p < 4; p++)
         begin
            md[p] = 1 + (p + q) % 3;
            mk[p] = (p + 2) % 4;
            iv[p] = (p + q) % 2;
            bs[p] = $urandom_range(16'hffff);
            wr(8'(APS_ADDR_BASE_HI0 + p), bs[p][15:8]);
            wr(8'(APS_ADDR_BASE_LO0 + p), bs[p][7:0]);
            rd(8'(APS_ADDR_BASE_HI0 + p), bs[p][15:8]);
         end
         a = md[1] * 64 + mk[1] * 16 + md[0] * 4 + mk[0];
         wr(APS_ADDR_MODE_A, 8'(a));
         rd(APS_ADDR_MODE_A, 8'(a));
         a = md[3] * 64 + mk[3] * 16 + md[2] * 4 + mk[2];
         wr(APS_ADDR_MODE_B, 8'(a));
         a = (iv[0] + iv[1] * 2 + iv[2] * 4 + iv[3] * 8) * 16;
         wr(APS_ADDR_EXT_CTRL, 8'(a));
         for (int k = 0; k < 60; k++)
         begin
            sel = $urandom_range(3);
            a = bs[sel] + $urandom_range(7);
            r = (k == 59) ? 0 : $urandom_range(2);
            ext_addr = a[15:0];
            ext_rd_n = (r != 1);
            ext_wr_n = (r != 2);
            for (int p = 0; p < 4; p++)
               e[p] = strobe(p, a, int'(r != 1), int'(r != 2));
            exp_q.push_back(e[3:0]);
            cyc(1);
            e = {4'h0, exp_q.pop_front()};
            chk_pin({4'h0, pin_out}, e);
            chk_pin({pin_oe_n, pin_out}, e);
         end
      end
      wr(APS_ADDR_PORT_DATA, 8'($urandom_range(255)));
      cyc(1);
      chk_pin({pin_oe_n, pin_out}, e);
      rst = 1'b1;
      cyc(2);
      chk_pin({pin_oe_n, pin_out}, 8'hf0);
      rst = 1'b0;
      cyc(1);
      chk_pin({6'h0, ext_irq_a_n, ext_irq_b_n}, 8'h03);
      rd(APS_ADDR_MODE_A, 8'h00);
      end_of_test();
   end
endmodule // aps_aux_port_bench
